//--- hw/dst_consts.vh
`ifndef DST_CONSTS_VH
`define DST_CONSTS_VH
// ----------------------------------------
// Frame and data widths
// ----------------------------------------
`define DST_SHIFT_W 32
`define DST_CHAN_N 5
`define DST_DATA_W 16
`define DST_CMD_W 4
`define DST_ADDR_W 4
// Command word field positions (low 24 bits of the shift register)
`define DST_CMD_HI 23
`define DST_CMD_LO 20
`define DST_ADDR_HI 19
`define DST_ADDR_LO 16
// Synchroniser reset: select high, SCK low, SDI high, toggle high, load high
`define DST_PIN_IDLE 5'h1d
// ----------------------------------------
// Frame lengths in bits
// ----------------------------------------
`define DST_FRAME_SHORT 24
`define DST_FRAME_LONG 32
// ----------------------------------------
// Command FIFO
// ----------------------------------------
`define DST_FIFO_W 24
`define DST_FIFO_DEPTH 16
`define DST_FIFO_AW 4
`endif

//--- hw/dst_fifo.v
`timescale 1ns/1ps
`default_nettype none
module dst_fifo #(
  parameter W = 24,
  parameter DEPTH = 16,
  parameter AW = 4
)
(
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_b_i,
  // Write side
  input wire wr_valid_i,
  output wire wr_ready_o,
  input wire [W-1:0] wr_data_i,
  // Read side
  output wire rd_valid_o,
  input wire rd_ready_i,
  output reg [W-1:0] rd_data_o
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  reg out_valid;
  wire [AW:0] used;
  wire mem_empty;
  wire load_out;
  wire [AW:0] held;
  assign used = wr_ptr - rd_ptr;
  assign mem_empty = (used == {(AW+1){1'b0}});
  // The output register is one of the DEPTH places, so full counts it too
  assign held = used + {{AW{1'b0}}, out_valid};
  assign wr_ready_o = (held != DEPTH[AW:0]);
  assign rd_valid_o = out_valid;
  // Output register refills whenever it is empty or being drained
  assign load_out = !mem_empty && (!out_valid || rd_ready_i);
  always @(posedge sys_clk_i)
  begin
    if (wr_valid_i && wr_ready_o)
    begin
      mem[wr_ptr[AW-1:0]] <= wr_data_i;
    end
  end
  always @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      rd_data_o <= {W{1'b0}};
    end
    else
    begin
      if (wr_valid_i && wr_ready_o)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (load_out)
      begin
        rd_data_o <= mem[rd_ptr[AW-1:0]];
        rd_ptr <= rd_ptr + 1'b1;
        out_valid <= 1'b1;
      end
      else if (rd_ready_i)
      begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- hw/dst_front_end.v
`timescale 1ns/1ps
`default_nettype none
`include "dst_consts.vh"
// Overview of operation
// - Toggle pin falling edge copies input register A to enabled DAC registers
// - Toggle pin rising edge copies input register B to enabled DAC registers
// - Toggle edges touch only channels whose toggle select bit is one
// - Serial input is shifted in on each SCK rising edge while selected
// - Frames of 24, 32 or multiples of 32 bits are all accepted
// - Serial output comes from the last stage of the 32-bit shift register
// - Serial output changes on the SCK falling edge after the 32nd rise
// - Serial output is high impedance while chip select/load is high
// - While chip select/load is low SCK shifts and serial output drives
// - Rising chip select/load stops shifting, releases output, runs command
// - Serial output allows echo readback or daisy chaining
// - Async load falling edge with select high updates all DAC registers
module dst_front_end
(
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_b_i,
  // Serial pins
  input wire chip_select_load_i,
  input wire sck_i,
  input wire sdi_i,
  output reg sdo_o,
  output wire sdo_oe_o,
  // Update pins
  input wire toggle_pin_i,
  input wire async_load_pin_i,
  // Channel state
  input wire [`DST_CHAN_N-1:0] toggle_sel_i,
  input wire [`DST_CHAN_N*`DST_DATA_W-1:0] input_reg_a_i,
  input wire [`DST_CHAN_N*`DST_DATA_W-1:0] input_reg_b_i,
  output wire [`DST_CHAN_N*`DST_DATA_W-1:0] dac_reg_o,
  // Decoded commands
  output wire cmd_valid_o,
  input wire cmd_ready_i,
  output wire [`DST_CMD_W-1:0] cmd_code_o,
  output wire [`DST_ADDR_W-1:0] cmd_addr_o,
  output wire [`DST_DATA_W-1:0] cmd_data_o,
  output wire cmd_overflow_o
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Bit positions of the pins inside the synchroniser words
  localparam PIN_CSL = 0;
  localparam PIN_SCK = 1;
  localparam PIN_SDI = 2;
  localparam PIN_TGL = 3;
  localparam PIN_LD = 4;
  // SCK is sampled, not used as a clock: each SCK phase must span several
  // system clocks, so the link runs far slower than the pin itself could
  reg [4:0] sync1;
  reg [4:0] sync2;
  reg [4:0] last;
  always @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      sync1 <= `DST_PIN_IDLE;
      sync2 <= `DST_PIN_IDLE;
      last <= `DST_PIN_IDLE;
    end
    else
    begin
      sync1 <= {async_load_pin_i, toggle_pin_i, sdi_i, sck_i, chip_select_load_i};
      sync2 <= sync1;
      last <= sync2;
    end
  end
  wire csl = sync2[PIN_CSL];
  wire sck_rise = sync2[PIN_SCK] && !last[PIN_SCK];
  wire sck_fall = !sync2[PIN_SCK] && last[PIN_SCK];
  wire sdi = sync2[PIN_SDI];
  wire tgl_rise = sync2[PIN_TGL] && !last[PIN_TGL];
  wire tgl_fall = !sync2[PIN_TGL] && last[PIN_TGL];
  wire ld_fall = !sync2[PIN_LD] && last[PIN_LD];
  wire csl_rise = csl && !last[PIN_CSL];
  wire csl_fall = !csl && last[PIN_CSL];
  // ----------------------------------------
  // Shift register and serial output
  // ----------------------------------------
  reg [`DST_SHIFT_W-1:0] shreg;
  reg [5:0] bit_cnt;
  reg any_bits;
  always @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      shreg <= 32'h00000000;
      bit_cnt <= 6'h00;
      any_bits <= 1'b0;
    end
    else if (csl_fall)
    begin
      bit_cnt <= 6'h00;
      any_bits <= 1'b0;
    end
    else if (!csl && sck_rise)
    begin
      shreg <= {shreg[`DST_SHIFT_W-2:0], sdi};
      any_bits <= 1'b1;
      // Counting modulo 32 lets long frames keep a valid 24/32 alignment
      if (bit_cnt == 6'd31)
      begin
        bit_cnt <= 6'h00;
      end
      else
      begin
        bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end
  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  // Before the first fall of a frame SDO shows the top bit left by the
  // previous frame; a bit shifted in 32 rises ago leaves on the next fall
  always @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      sdo_o <= 1'b0;
    end
    else if (csl_fall)
    begin
      sdo_o <= shreg[`DST_SHIFT_W-1];
    end
    else if (!csl && sck_fall)
    begin
      sdo_o <= shreg[`DST_SHIFT_W-1];
    end
  end
  // Enable follows the synchronised select, so release lags the pin slightly
  assign sdo_oe_o = !csl;
  // ----------------------------------------
  // Frame end: command into the FIFO
  // ----------------------------------------
  // A 24-bit frame leaves the word in bits 23:0; a 32-bit multiple leaves
  // it in the same place with eight ignored bits above, so both take 23:0.
  wire frame_ok = any_bits && ((bit_cnt == 6'd24) || (bit_cnt == 6'd0));
  wire push = csl_rise && frame_ok;
  wire fifo_wr_ready;
  wire [`DST_FIFO_W-1:0] fifo_out;
  reg overflow;
  always @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      overflow <= 1'b0;
    end
    else if (push && !fifo_wr_ready)
    begin
      overflow <= 1'b1;
    end
  end
  assign cmd_overflow_o = overflow;
  dst_fifo #(
    .W(`DST_FIFO_W),
    .DEPTH(`DST_FIFO_DEPTH),
    .AW(`DST_FIFO_AW)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .wr_valid_i(push),
    .wr_ready_o(fifo_wr_ready),
    .wr_data_i(shreg[`DST_FIFO_W-1:0]),
    .rd_valid_o(cmd_valid_o),
    .rd_ready_i(cmd_ready_i),
    .rd_data_o(fifo_out)
  );
  assign cmd_code_o = fifo_out[`DST_CMD_HI:`DST_CMD_LO];
  assign cmd_addr_o = fifo_out[`DST_ADDR_HI:`DST_ADDR_LO];
  assign cmd_data_o = fifo_out[`DST_DATA_W-1:0];
  // ----------------------------------------
  // DAC register updates
  // ----------------------------------------
  wire ld_go = ld_fall && csl;
  genvar ch;
  generate
    for (ch = 0; ch < `DST_CHAN_N; ch = ch + 1)
    begin : g_chan
      wire [`DST_DATA_W-1:0] word_a = input_reg_a_i[ch*`DST_DATA_W +: `DST_DATA_W];
      wire [`DST_DATA_W-1:0] word_b = input_reg_b_i[ch*`DST_DATA_W +: `DST_DATA_W];
      reg [`DST_DATA_W-1:0] dac_q;
      reg [`DST_DATA_W-1:0] next_dac;
      // Load outranks a toggle edge in the same cycle: it updates every channel
      always @*
      begin
        next_dac = dac_q;
        if (ld_go)
        begin
          next_dac = word_a;
        end
        else if (toggle_sel_i[ch] && tgl_fall)
        begin
          next_dac = word_a;
        end
        else if (toggle_sel_i[ch] && tgl_rise)
        begin
          next_dac = word_b;
        end
      end
      always @(posedge sys_clk_i)
      begin
        if (!rst_b_i)
        begin
          dac_q <= 16'h0000;
        end
        else
        begin
          dac_q <= next_dac;
        end
      end
      assign dac_reg_o[ch*`DST_DATA_W +: `DST_DATA_W] = dac_q;
    end
  endgenerate
endmodule
`default_nettype wire

//--- test/dst_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dst_host_model (
  // Serial pins
  output var logic csl_o,
  output var logic sck_o,
  output var logic sdi_o,
  input wire logic sdo_i
);
  logic [31:0] echo;
  initial
  begin
    csl_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b1;
    echo = 32'h0;
  end
  // --
  // MSB first at 80 ns; SCK rests low between frames
  // --
  task automatic send(input int nbits, input logic [63:0] word);
    #13 csl_o = 1'b0;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      sdi_o = word[i];
      #40 sck_o = 1'b1;
      echo = {echo[30:0], sdo_i};
      #40 sck_o = 1'b0;
    end
    sdi_o = ~sdi_o;
    #40 csl_o = 1'b1;
    #40;
  endtask
endmodule
`default_nettype wire

//--- test/dst_front_end_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "dst_consts.vh"
module dst_fe_props (
  // Watched ports
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic chip_select_load_i,
  input wire logic sck_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic toggle_pin_i,
  input wire logic async_load_pin_i,
  input wire logic [`DST_CHAN_N-1:0] toggle_sel_i,
  input wire logic [`DST_CHAN_N*`DST_DATA_W-1:0] input_reg_a_i,
  input wire logic [`DST_CHAN_N*`DST_DATA_W-1:0] input_reg_b_i,
  input wire logic [`DST_CHAN_N*`DST_DATA_W-1:0] dac_reg_o,
  input wire logic cmd_valid_o
);
  // Pins pass a synchroniser, so windows allow a few cycles of lag
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  a_oe_off: assert property (chip_select_load_i[*5] |-> !sdo_oe_o)
    else $error("sdo driven");
  a_oe_on: assert property ((!chip_select_load_i)[*5] |-> sdo_oe_o)
    else $error("sdo released");
  a_tog_fall: assert property ($fell(toggle_pin_i) && toggle_sel_i[0] |->
    ##[1:8] dac_reg_o[15:0] == input_reg_a_i[15:0]) else $error("no A copy");
  a_tog_rise: assert property ($rose(toggle_pin_i) && toggle_sel_i[0] |->
    ##[1:8] dac_reg_o[15:0] == input_reg_b_i[15:0]) else $error("no B copy");
  a_tog_sel: assert property ((!toggle_sel_i[1] && async_load_pin_i)[*5] |=>
    $stable(dac_reg_o[31:16])) else $error("channel moved");
  a_load_all: assert property (chip_select_load_i[*4] ##0 $fell(async_load_pin_i) |->
    ##[1:8] dac_reg_o == input_reg_a_i) else $error("no load");
  a_sdo_hold: assert property ((!chip_select_load_i && sck_i)[*6] |=> $stable(sdo_o))
    else $error("sdo moved");
  a_cmd_quiet: assert property ((!chip_select_load_i)[*6] ##0 !cmd_valid_o |=> !cmd_valid_o)
    else $error("early command");
endmodule
bind dst_front_end dst_fe_props dst_fe_props_i (.*);
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic toggle_pin_i = 1'b1;
  logic async_load_pin_i = 1'b1;
  logic cmd_ready_i = 1'b0;
  logic [4:0] toggle_sel_i = 5'h05;
  logic [79:0] input_reg_a_i = 80'h1111_2222_3333_4444_5555;
  logic [79:0] input_reg_b_i = 80'h6666_7777_8888_9999_bbbb;
  wire csl, sck, sdi, sdo_o, sdo_oe_o, cmd_valid_o, cmd_overflow_o;
  wire sdo_line = sdo_oe_o ? sdo_o : 1'bz;
  wire [79:0] dac_reg_o;
  wire [3:0] cmd_code_o, cmd_addr_o;
  wire [15:0] cmd_data_o;
  int fail_count = 0;
  int num_checks = 0;
  int n;
  logic got;
  // --
  // Frame table: length, word, command expected, word expected
  // --
  int nb [4] = '{24, 32, 64, 20};
  logic [63:0] wd [4] = '{64'h31a5c3, 64'h7f421234, 64'h9abcdef0_13572468, 64'habcde};
  logic ev [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  logic [23:0] ec [4] = '{24'h31a5c3, 24'h421234, 24'h572468, 24'h0};
  always #2.5 sys_clk_i = ~sys_clk_i;
  dst_host_model dst_host_model_i (.csl_o(csl), .sck_o(sck), .sdi_o(sdi), .sdo_i(sdo_line));
  dst_front_end dst_front_end_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .chip_select_load_i(csl), .sck_i(sck), .sdi_i(sdi), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .toggle_pin_i(toggle_pin_i), .async_load_pin_i(async_load_pin_i),
    .toggle_sel_i(toggle_sel_i), .input_reg_a_i(input_reg_a_i), .input_reg_b_i(input_reg_b_i),
    .dac_reg_o(dac_reg_o), .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i),
    .cmd_code_o(cmd_code_o), .cmd_addr_o(cmd_addr_o), .cmd_data_o(cmd_data_o),
    .cmd_overflow_o(cmd_overflow_o));
  task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_cmd(output logic seen);
    seen = 1'b0;
    repeat (40)
    begin
      @(negedge sys_clk_i);
      if (cmd_valid_o === 1'b1)
      begin
        seen = 1'b1;
        break;
      end
    end
  endtask
  task automatic pop;
    @(posedge sys_clk_i);
    cmd_ready_i <= 1'b1;
    @(posedge sys_clk_i);
    cmd_ready_i <= 1'b0;
  endtask
  task automatic pin_step(input logic tog, input logic ld);
    @(posedge sys_clk_i);
    toggle_pin_i <= tog;
    async_load_pin_i <= ld;
    repeat (10) @(posedge sys_clk_i);
  endtask
  initial
  begin
    #150000;
    fail_count++;
    finish_test;
  end
  initial
  begin
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    check("oe_rst", sdo_oe_o, 1'b0);
    for (int r = 0; r < 4; r++)
    begin
      dst_host_model_i.send(nb[r], wd[r]);
      wait_cmd(got);
      check("cmd_valid", got, ev[r]);
      if (ev[r])
        check("cmd_word", {cmd_code_o, cmd_addr_o, cmd_data_o}, ec[r]);
      if (ev[r])
        pop;
      if (nb[r] == 64)
        check("echo", dst_host_model_i.echo, wd[r][63:32]);
    end
    pin_step(1'b0, 1'b1);
    check("dac_fall", dac_reg_o, 80'h0000_0000_3333_0000_5555);
    pin_step(1'b1, 1'b1);
    check("dac_rise", dac_reg_o, 80'h0000_0000_8888_0000_bbbb);
    pin_step(1'b1, 1'b0);
    check("dac_load", dac_reg_o, input_reg_a_i);
    check("ovf_idle", cmd_overflow_o, 1'b0);
    repeat (17) dst_host_model_i.send(24, 64'h123456);
    check("ovf", cmd_overflow_o, 1'b1);
    n = 0;
    repeat (17)
    begin
      wait_cmd(got);
      if (got)
        n++;
      if (got)
        pop;
    end
    check("drained", 80'(n), 80'd16);
    finish_test;
  end
endmodule
`default_nettype wire
